/* File: asb_pkg.sv */
// Package for the asynchronous byte memory host controller.
// Assumes a 100 MHz reference clock; all pin timings are derived from it.
package asb_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;

    // Faster grade figures in ns.
    localparam int ADDRESS_ACCESS_DELAY_NS = 55;
    localparam int SELECT_ACCESS_DELAY_NS = 55;
    localparam int OUTPUT_ENABLE_ACCESS_DELAY_NS = 25;
    localparam int DESELECT_TO_STANDBY_DELAY_NS = 55;
    localparam int OUTPUT_TURNOFF_NS = 20;
    localparam int WRITE_DATA_SETUP_NS = 25;
    localparam int WRITE_DATA_HOLD_NS = 0;
    localparam int ADDRESS_SETUP_TO_WRITE_END_NS = 45;
    localparam int ADDRESS_SETUP_TO_WRITE_START_NS = 0;
    localparam int ADDRESS_HOLD_AFTER_WRITE_NS = 0;
    localparam int WRITE_STROBE_OUTPUT_TURNOFF_NS = 20;

    // Minimum times round up to whole cycles, never below one.
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // Read waits for the slowest of the three access paths.
    localparam int READ_WAIT_CYC = ns_to_cyc(ADDRESS_ACCESS_DELAY_NS);
    localparam int OE_WAIT_CYC = ns_to_cyc(OUTPUT_ENABLE_ACCESS_DELAY_NS);
    // Write strobe low time covers address setup and turnoff plus data setup.
    localparam int WRITE_PULSE_CYC = ns_to_cyc(ADDRESS_SETUP_TO_WRITE_END_NS);
    localparam int TURNOFF_CYC = ns_to_cyc(WRITE_STROBE_OUTPUT_TURNOFF_NS);
    localparam int DATA_SETUP_CYC = ns_to_cyc(WRITE_DATA_SETUP_NS);
    localparam int BUS_RELEASE_CYC = ns_to_cyc(OUTPUT_TURNOFF_NS);
    localparam int CNT_W = 8;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asb_req_t;

    typedef struct packed {
        logic select_n;
        logic out_en_n;
        logic write_n;
        logic [ADDR_W-1:0] addr;
    } asb_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_RD_WAIT, ST_WR_PULSE, ST_RECOVER
    } asb_state_t;

endpackage

/* File: asb_sync.sv */
// Two-stage synchroniser for the byte-wide data lines read back from the memory.
// Assumes the data pins are asynchronous to ref_clk.
`timescale 1ns/10ps
module asb_sync
    import asb_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    // Clocking
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    if (WIDTH < 1)
        $error("synchroniser width must be positive");

    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end

endmodule

/* File: asb_host.sv */
// Host controller driving an asynchronous byte-wide static memory.
// Assumes one request at a time on the user side and a memory on pins.
//
// Summary of operation
// - Read: write strobe high, select and output enable low, memory drives data.
// - Write happens while select and strobe both low; strobe rise ends it.
// - Data setup and hold are timed to the write-ending strobe edge.
// - Write data stable 25 ns before write end, held through the edge.
// - Address stable at least 45 ns before the write-ending edge.
// - Address set on the write-start edge and held through write end.
// - Host does not drive data lines until memory outputs turned off.
// - Strobe-controlled write with enable low lasts turnoff plus setup.
`timescale 1ns/10ps
module asb_host
    import asb_pkg::*;
#(
    parameter int RD_CYC = READ_WAIT_CYC,
    parameter int WR_CYC = WRITE_PULSE_CYC,
    parameter int REC_CYC = BUS_RELEASE_CYC
) (
    // Clocking
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // User request
    input wire logic req_valid,
    output logic req_ready,
    input wire asb_req_t req,
    // User answer
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    // Memory pins
    output asb_pins_t pins,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_n
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Cycle covers turnoff plus setup
    if (WR_CYC < TURNOFF_CYC + DATA_SETUP_CYC || WR_CYC < ns_to_cyc(ADDRESS_SETUP_TO_WRITE_END_NS))
        $error("write pulse too short");
    if (RD_CYC < OE_WAIT_CYC || RD_CYC + 2 >= (1 << CNT_W) || WR_CYC >= (1 << CNT_W) || REC_CYC < 1)
        $error("bad cycle counts");

    // ------------------------------------------------------------
    // Data line synchroniser
    // ------------------------------------------------------------
    logic [DATA_W-1:0] data_sync;

    asb_sync #(.WIDTH(DATA_W)) u_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .async_in(data_in),
        .sync_out(data_sync)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    asb_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic wr_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic select_n_ff, out_en_n_ff, write_n_ff;

    // A phase that lasts cyc enabled edges loads cyc - 1 and ends on zero.
    function automatic logic [CNT_W-1:0] cnt_load(input int cyc);
        return CNT_W'(cyc - 1);
    endfunction

    // Next-state decodes shared by several pin registers.
    function automatic logic is_read(input asb_state_t st);
        return st == ST_RD_WAIT;
    endfunction

    function automatic logic is_write(input asb_state_t st);
        return st == ST_WR_PULSE;
    endfunction

    assign req_ready = (state_ff == ST_IDLE);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = (cnt_ff == '0) ? cnt_ff : cnt_ff - CNT_W'(1);
        case (state_ff)
            ST_IDLE: begin
                if (req_valid) begin
                    nxt_state = req.write ? ST_WR_PULSE : ST_RD_WAIT;
                    // Two extra cycles let the synchroniser catch settled data.
                    nxt_cnt = req.write ? cnt_load(WR_CYC) : cnt_load(RD_CYC + 2);
                end
            end
            ST_RD_WAIT: begin
                if (cnt_ff == '0) begin
                    nxt_state = ST_RECOVER;
                    nxt_cnt = cnt_load(REC_CYC);
                end
            end
            ST_WR_PULSE: begin
                if (cnt_ff == '0) begin
                    nxt_state = ST_RECOVER;
                    nxt_cnt = cnt_load(REC_CYC);
                end
            end
            ST_RECOVER: begin
                if (cnt_ff == '0) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // ------------------------------------------------------------
    // Address and write data latch
    // ------------------------------------------------------------
    // Address held across access
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_ff <= '0;
            wr_ff <= 1'b0;
        end else if (clk_en && req_valid && req_ready) begin
            addr_ff <= req.addr;
            wr_ff <= req.write;
        end
    end

    // Data held past write end
    // The byte only changes at the next take, but data_oe_n rises on the ending edge, so the driven hold is zero.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_out <= '0;
        end else if (clk_en && req_valid && req_ready) begin
            data_out <= req.wdata;
        end
    end

    // ------------------------------------------------------------
    // Pin controls
    // ------------------------------------------------------------
    // Controls are registered so that no glitch reaches the memory.
    // Address and controls leave on one edge; board skew must not let a control lead the address.
    // Select any access
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            select_n_ff <= 1'b1;
        end else if (clk_en) begin
            select_n_ff <= !(is_read(nxt_state) || is_write(nxt_state));
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_en_n_ff <= 1'b1;
        end else if (clk_en) begin
            out_en_n_ff <= !is_read(nxt_state);
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            write_n_ff <= 1'b1;
        end else if (clk_en) begin
            write_n_ff <= !is_write(nxt_state);
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_oe_n <= 1'b1;
        end else if (clk_en) begin
            data_oe_n <= !is_write(nxt_state);
        end
    end

    assign pins = '{select_n: select_n_ff, out_en_n: out_en_n_ff, write_n: write_n_ff, addr: addr_ff};

    // ------------------------------------------------------------
    // Read answer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else if (clk_en) begin
            rsp_valid <= 1'b0;
            if (state_ff == ST_RD_WAIT && cnt_ff == '0 && !wr_ff) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= data_sync;
            end
        end
    end

endmodule

/* File: asb_mem_model.sv */
// Behavioural byte-wide asynchronous memory standing on the host's pins.
// Assumes the host drives the controls and address through asb_pins_t and the data lines on data_out.
`timescale 1ns/10ps
module asb_mem_model
    import asb_pkg::*;
(
    // Host pins
    input wire asb_pins_t pins,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic data_oe_n,
    // Answer speed
    input wire logic slow,
    // Memory data
    output logic [DATA_W-1:0] data_in
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    realtime t_chg = 0.0;
    logic rd_on;
    logic wr_on;
    assign rd_on = !pins.select_n && !pins.out_en_n && pins.write_n;
    assign wr_on = !pins.select_n && !pins.write_n;
    always @(pins.addr or rd_on) t_chg = $realtime;
    // Write through overlap
    // The byte standing just before the ending edge is kept, as a zero hold time allows.
    always @(pins.addr or data_out or data_oe_n or wr_on) begin
        if (wr_on && !data_oe_n) mem[pins.addr] = data_out;
    end
    // Access and hold
    // Undriven lines toggle so that no stale byte can pass for a good one.
    initial begin
        data_in = 8'h5a;
        forever begin
            #1;
            if (rd_on && $realtime - t_chg >= (slow ? 55.0 : 5.0)) data_in = mem[pins.addr];
            else if ($realtime - t_chg >= 5.0) data_in = ~data_in;
        end
    end
endmodule

/* File: asb_host_chk.sv */
// Pin sequencing checks for the byte memory host controller.
// Assumes it is bound to asb_host and sees only its ports.
`timescale 1ns/10ps
module asb_host_chk
    import asb_pkg::*;
(
    // Clocking
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // User side
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rsp_valid,
    // Memory pins
    input wire asb_pins_t pins,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic data_oe_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    property p_rd; !pins.out_en_n |-> pins.write_n && !pins.select_n; endproperty
    a_rd: assert property (p_rd) else $error("read controls");
    property p_wr; !pins.write_n |-> !pins.select_n && pins.out_en_n; endproperty
    a_wr: assert property (p_wr) else $error("write controls");
    property p_end; $rose(pins.write_n) |-> $rose(pins.select_n); endproperty
    a_end: assert property (p_end) else $error("write end split");
    property p_len; $fell(pins.write_n) |-> !pins.write_n [*5]; endproperty
    a_len: assert property (p_len) else $error("short strobe");
    property p_hold; !$past(pins.write_n) |-> $stable(data_out) && $stable(pins.addr); endproperty
    a_hold: assert property (p_hold) else $error("write moved");
    property p_drv; !data_oe_n |-> !pins.write_n && pins.out_en_n; endproperty
    a_drv: assert property (p_drv) else $error("contention");
    property p_acc; $fell(pins.out_en_n) |-> !pins.out_en_n [*6]; endproperty
    a_acc: assert property (p_acc) else $error("early sample");
    property p_rsp; $rose(rsp_valid) |-> !$past(pins.out_en_n); endproperty
    a_rsp: assert property (p_rsp) else $error("answer unread");
    property p_idle; req_ready |-> pins.select_n && pins.write_n; endproperty
    a_idle: assert property (p_idle) else $error("idle selected");
    cover property ($rose(rsp_valid));
    cover property ($fell(pins.write_n));
    cover property (req_valid && req_ready && !clk_en);
endmodule
bind asb_host asb_host_chk asb_host_chk_inst (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
    .req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid), .pins(pins),
    .data_out(data_out), .data_oe_n(data_oe_n));

/* File: asb_host_test.sv */
// Self-checking bench for the byte memory host controller.
// Assumes the behavioural memory model answers on the pins.
`timescale 1ns/10ps
`define CHK(g, e, w) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %s exp %h got %h", w, e, g); end end
module asb_host_test import asb_pkg::*; ();
    logic ref_clk, arst_n, clk_en, req_valid, req_ready, rsp_valid, data_oe_n, slow;
    asb_req_t req;
    asb_pins_t pins;
    logic [DATA_W-1:0] rsp_rdata, data_in, data_out, d;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] ref_mem [int];
    int tests_run, n_fail, i;

    asb_host asb_host_inst (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins(pins),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));
    asb_mem_model asb_mem_model_inst (.pins(pins), .data_out(data_out), .data_oe_n(data_oe_n),
        .slow(slow), .data_in(data_in));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [DATA_W-1:0] exp_rd(input logic [ADDR_W-1:0] adr);
        return ref_mem.exists(adr) ? ref_mem[adr] : 8'h00;
    endfunction

    task automatic end_of_test;
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Random clock-enable stalls stretch every phase of the access.
    task automatic op(input logic w, input logic [ADDR_W-1:0] adr, input logic [DATA_W-1:0] dat);
        int n;
        // One idle edge keeps valid from being lowered and raised in one step.
        @(negedge ref_clk);
        req = '{w, adr, dat};
        req_valid = 1'b1;
        // The take happens at the next rising edge exactly when ready and enable stand here.
        for (n = 0; n < 400; n++) begin
            clk_en = ($urandom % 4) != 0;
            if (req_ready && clk_en) break;
            @(negedge ref_clk);
        end
        @(negedge ref_clk);
        req_valid = 1'b0;
        for (; n < 400 && !w && !rsp_valid; n++) begin
            clk_en = ($urandom % 4) != 0;
            @(negedge ref_clk);
        end
        if (n >= 400) begin
            n_fail++;
            end_of_test();
        end else if (!w) `CHK(rsp_rdata, exp_rd(adr), "read data")
        else ref_mem[adr] = dat;
    endtask

    initial begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        req_valid = 1'b0;
        req = '0;
        slow = 1'b1;
        tests_run = 0;
        n_fail = 0;
        void'($urandom(32'h3ca0));
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        arst_n = 1'b1;
        op(1'b1, 15'h7fff, 8'hff);
        op(1'b1, 15'h0000, 8'h00);
        op(1'b0, 15'h7fff, 8'h00);
        op(1'b0, 15'h0000, 8'h00);
        for (i = 0; i < 60; i++) begin
            a = ADDR_W'($urandom);
            d = DATA_W'($urandom);
            slow = 1'($urandom);
            op(1'b1, a, d);
            op(1'b0, a, 8'h00);
        end
        @(negedge ref_clk);
        clk_en = 1'b1;
        req = '{1'b0, 15'h7fff, 8'h00};
        req_valid = 1'b1;
        repeat (4) @(negedge ref_clk);
        arst_n = 1'b0;
        req_valid = 1'b0;
        #1 `CHK(pins, 18'h38000, "pins in reset")
        `CHK(data_oe_n, 1'b1, "bus released")
        `CHK(rsp_valid, 1'b0, "answer cleared")
        @(negedge ref_clk);
        arst_n = 1'b1;
        op(1'b0, 15'h7fff, 8'h00);
        end_of_test();
    end
endmodule
